// ==== hw/viack_pkg.sv ====
// constants and types for the vectored interrupt acknowledge block
package viack_pkg;
  localparam int NUM_EXT = 12;
  localparam int NUM_SRC = 16;
  localparam int SRC_W = 4;
  localparam logic [7:0] STATUS_RST = 8'h02;
  localparam int IE_BIT = 7;
  localparam int ISP_BIT = 1;
  localparam logic [15:0] TRAP_VEC_LO = 16'h003e;
  localparam logic [15:0] TRAP_VEC_HI = 16'h003f;
  localparam logic [15:0] VEC_TABLE_BASE = 16'h0004;
  localparam int MIN_LAT_HI = 7;
  localparam int MIN_LAT_LO = 8;
  localparam int MAX_LAT_HI = 32;
  localparam int MAX_LAT_LO = 33;
  localparam int LAT_W = 6;
  // avalon register offsets (byte addresses)
  localparam logic [3:0] REG_RISE = 4'h0;
  localparam logic [3:0] REG_FALL = 4'h4;
  localparam logic [3:0] REG_MASK = 4'h8;
  localparam logic [3:0] REG_LEVEL = 4'hc;
  localparam int ADDR_W = 4;
  typedef enum logic [4:0] {
    VIACK_IDLE = 5'h01,
    VIACK_WAIT = 5'h02,
    VIACK_PUSH_STATUS_INSTR = 5'h04,
    VIACK_PUSH_PC = 5'h08,
    VIACK_VECTOR = 5'h10
  } viack_state_t;
endpackage

// ==== hw/viack_top.sv ====
// vectored interrupt acknowledge: edge detect, status word, arbitration, stacking, trap
//
// Local design decisions: the Avalon-MM register port and the register offsets.
`timescale 1ns/100ps
module viack_top #(
  parameter int NUM_EXT = viack_pkg::NUM_EXT,
  parameter int NUM_SRC = viack_pkg::NUM_SRC
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // external pins
  input wire logic [NUM_EXT-1:0] ext_irq_pin_i,
  // internal peripheral request pulses
  input wire logic [NUM_SRC-1:0] periph_req_i,
  // avalon-mm slave
  input wire logic [viack_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // core sequencer
  input wire logic instr_boundary_i,
  input wire logic div_busy_i,
  input wire logic set_enable_instr_i,
  input wire logic clear_enable_instr_i,
  input wire logic break_trap_instr_i,
  input wire logic return_from_irq_instr_i,
  input wire logic return_from_trap_instr_i,
  input wire logic pop_status_instr_i,
  input wire logic [7:0] stack_status_i,
  input wire logic status_wr_i,
  input wire logic [7:0] status_wdata_i,
  input wire logic status_bit_set_i,
  input wire logic status_bit_clr_i,
  input wire logic [2:0] status_bit_sel_i,
  output logic [7:0] status_word_o,
  output logic push_status_o,
  output logic push_pc_o,
  output logic vector_load_o,
  output logic [15:0] vector_addr_o,
  output logic [viack_pkg::SRC_W-1:0] vector_src_o,
  output logic trap_active_o,
  output logic [NUM_SRC-1:0] ext_irq_request_o
);
  import viack_pkg::*;

  logic [NUM_EXT-1:0] rise_edge_select_q;
  logic [NUM_EXT-1:0] fall_edge_select_q;
  logic [NUM_SRC-1:0] mask_flag_q;
  logic [NUM_SRC-1:0] level_select_flag_q;
  logic [NUM_SRC-1:0] req_q;
  logic [NUM_SRC-1:0] ext_evt;
  logic [NUM_EXT-1:0] s1_q;
  logic [NUM_EXT-1:0] s2_q;
  logic [NUM_EXT-1:0] s3_q;
  logic [NUM_EXT-1:0] lvl_q;
  logic [7:0] status_word_q;
  viack_state_t state_q;
  logic [SRC_W-1:0] win_q;
  logic win_lvl_q;
  logic is_trap_q;
  logic [LAT_W-1:0] lat_q;
  logic [31:0] rdata_q;
  logic wait_q;
  logic wr_take;
  logic trap_pend_q;
  logic trap_req;
  logic in_seq;

  // one-hot register select codes
  localparam logic [3:0] SEL_RISE = 4'h1;
  localparam logic [3:0] SEL_FALL = 4'h2;
  localparam logic [3:0] SEL_MASK = 4'h4;
  localparam logic [3:0] SEL_LEVEL = 4'h8;

  // synchronise pins; edge counts once second and third stages agree
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
    end else begin
      s1_q <= ext_irq_pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < NUM_EXT; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          lvl_q[i] <= s3_q[i];
        end
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_evt
      if (g < NUM_EXT) begin : g_pin
        logic settled_change;
        logic rose;
        logic fell;
        // a change counts once the second and third stages agree
        assign settled_change = (s2_q[g] == s3_q[g]) && (s3_q[g] != lvl_q[g]);
        assign rose = settled_change && s3_q[g] && rise_edge_select_q[g];
        assign fell = settled_change && !s3_q[g] && fall_edge_select_q[g];
        assign ext_evt[g] = rose || fell;
      end else begin : g_none
        assign ext_evt[g] = 1'b0;
      end
    end
  endgenerate

  // lowest set index wins: fixed default order
  function automatic logic [SRC_W-1:0] pick(input logic [NUM_SRC-1:0] v);
    logic [SRC_W-1:0] r;
    r = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = SRC_W'(i);
      end
    end
    return r;
  endfunction

  // one-hot register decode, shared by the read and the write path
  function automatic logic [3:0] reg_sel(input logic [ADDR_W-1:0] a);
    logic [3:0] r;
    r = 4'h0;
    case (a)
      REG_RISE: r = SEL_RISE;
      REG_FALL: r = SEL_FALL;
      REG_MASK: r = SEL_MASK;
      REG_LEVEL: r = SEL_LEVEL;
      default: r = 4'h0;
    endcase
    return r;
  endfunction

  // eligibility, level gating and arbitration
  logic [NUM_SRC-1:0] elig;
  logic [NUM_SRC-1:0] elig_hi;
  logic [NUM_SRC-1:0] elig_ok;
  logic any_ok;
  logic [SRC_W-1:0] sel;
  logic lat_min_met;
  logic accept_go;
  logic ack_clr;
  assign elig = req_q & ~mask_flag_q;
  assign elig_hi = elig & ~level_select_flag_q;
  assign elig_ok = status_word_q[ISP_BIT] ? elig : elig_hi;
  assign any_ok = |elig_ok;
  assign sel = (|(elig_ok & ~level_select_flag_q)) ?
    pick(elig_ok & ~level_select_flag_q) : pick(elig_ok);
  assign lat_min_met = level_select_flag_q[sel] ?
    (lat_q >= LAT_W'(MIN_LAT_LO)) : (lat_q >= LAT_W'(MIN_LAT_HI));
  assign accept_go = lat_min_met && instr_boundary_i && !div_busy_i;
  // a granted source drops its flag in the vector cycle
  assign ack_clr = (state_q == VIACK_VECTOR) && !is_trap_q;

  // request flags: event set wins over acceptance clear
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      req_q <= '0;
    end else begin
      for (int i = 0; i < NUM_SRC; i++) begin
        if (ext_evt[i] || periph_req_i[i]) begin
          req_q[i] <= 1'b1;
        end else if (ack_clr && win_q == SRC_W'(i)) begin
          req_q[i] <= 1'b0;
        end
      end
    end
  end

  // a break met while a sequence runs is held, so no trap is ever dropped
  assign in_seq = (state_q != VIACK_IDLE) && (state_q != VIACK_WAIT);
  assign trap_req = break_trap_instr_i || trap_pend_q;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trap_pend_q <= 1'b0;
    end else if (break_trap_instr_i && in_seq) begin
      trap_pend_q <= 1'b1;
    end else if (!in_seq) begin
      trap_pend_q <= 1'b0;
    end
  end

  // waiting time since the request was seen; saturates rather than wraps
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lat_q <= '0;
    end else if (state_q != VIACK_WAIT) begin
      lat_q <= '0;
    end else if (lat_q != '1) begin
      lat_q <= lat_q + LAT_W'(1);
    end
  end

  // acceptance sequencer
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= VIACK_IDLE;
      win_q <= '0;
      win_lvl_q <= 1'b1;
      is_trap_q <= 1'b0;
    end else begin
      case (state_q)
        VIACK_IDLE: begin
          if (trap_req) begin
            is_trap_q <= 1'b1;
            state_q <= VIACK_PUSH_STATUS_INSTR;
          end else if (any_ok && status_word_q[IE_BIT]) begin
            state_q <= VIACK_WAIT;
          end
        end
        VIACK_WAIT: begin
          if (trap_req) begin
            is_trap_q <= 1'b1;
            state_q <= VIACK_PUSH_STATUS_INSTR;
          end else if (!(any_ok && status_word_q[IE_BIT])) begin
            state_q <= VIACK_IDLE;
          end else if (accept_go) begin
            win_q <= sel;
            win_lvl_q <= level_select_flag_q[sel];
            is_trap_q <= 1'b0;
            state_q <= VIACK_PUSH_STATUS_INSTR;
          end
        end
        // status byte first, then the program counter, then the vector fetch
        VIACK_PUSH_STATUS_INSTR: state_q <= VIACK_PUSH_PC;
        VIACK_PUSH_PC: state_q <= VIACK_VECTOR;
        VIACK_VECTOR: begin
          is_trap_q <= 1'b0;
          state_q <= VIACK_IDLE;
        end
        default: state_q <= VIACK_IDLE;
      endcase
    end
  end

  // status word
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_word_q <= STATUS_RST;
    end else if (state_q == VIACK_PUSH_STATUS_INSTR) begin
      status_word_q[IE_BIT] <= 1'b0;
      if (!is_trap_q) begin
        status_word_q[ISP_BIT] <= win_lvl_q;
      end
    end else if (return_from_irq_instr_i || return_from_trap_instr_i ||
                 pop_status_instr_i) begin
      status_word_q <= stack_status_i;
    end else if (status_wr_i) begin
      status_word_q <= status_wdata_i;
    end else if (status_bit_set_i) begin
      status_word_q[status_bit_sel_i] <= 1'b1;
    end else if (status_bit_clr_i) begin
      status_word_q[status_bit_sel_i] <= 1'b0;
    end else if (set_enable_instr_i) begin
      status_word_q[IE_BIT] <= 1'b1;
    end else if (clear_enable_instr_i) begin
      status_word_q[IE_BIT] <= 1'b0;
    end
  end

  // sequencer outputs
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      push_status_o <= 1'b0;
      push_pc_o <= 1'b0;
      vector_load_o <= 1'b0;
      vector_addr_o <= '0;
      vector_src_o <= '0;
      trap_active_o <= 1'b0;
    end else begin
      push_status_o <= (state_q == VIACK_PUSH_STATUS_INSTR);
      push_pc_o <= (state_q == VIACK_PUSH_PC);
      vector_load_o <= (state_q == VIACK_VECTOR);
      vector_src_o <= win_q;
      trap_active_o <= is_trap_q;
      vector_addr_o <= is_trap_q ? TRAP_VEC_LO :
        (VEC_TABLE_BASE + {11'h000, win_q, 1'b0});
    end
  end

  // registered copies of status and request flags
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_word_o <= STATUS_RST;
      ext_irq_request_o <= '0;
    end else begin
      status_word_o <= status_word_q;
      ext_irq_request_o <= req_q;
    end
  end

  // avalon slave: read data taken on the request edge, answered one cycle later
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wait_q <= 1'b1;
      rdata_q <= '0;
    end else if ((avs_read_i || avs_write_i) && wait_q) begin
      wait_q <= 1'b0;
      rdata_q <= '0;
      case (reg_sel(avs_address_i))
        SEL_RISE: rdata_q[NUM_EXT-1:0] <= rise_edge_select_q;
        SEL_FALL: rdata_q[NUM_EXT-1:0] <= fall_edge_select_q;
        SEL_MASK: rdata_q[NUM_SRC-1:0] <= mask_flag_q;
        SEL_LEVEL: rdata_q[NUM_SRC-1:0] <= level_select_flag_q;
        default: ;
      endcase
    end else begin
      wait_q <= 1'b1;
    end
  end

  // a write lands on the edge at which the master sees waitrequest low
  assign wr_take = avs_write_i && !wait_q;

  // edge selects, masks and levels; unmapped offsets swallow writes
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rise_edge_select_q <= '0;
      fall_edge_select_q <= '0;
      mask_flag_q <= '1;
      level_select_flag_q <= '1;
    end else if (wr_take) begin
      case (reg_sel(avs_address_i))
        SEL_RISE: rise_edge_select_q <= avs_writedata_i[NUM_EXT-1:0];
        SEL_FALL: fall_edge_select_q <= avs_writedata_i[NUM_EXT-1:0];
        SEL_MASK: mask_flag_q <= avs_writedata_i[NUM_SRC-1:0];
        SEL_LEVEL: level_select_flag_q <= avs_writedata_i[NUM_SRC-1:0];
        default: ;
      endcase
    end
  end

  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o = rdata_q;
endmodule

// ==== test/viack_core_model.sv ====
// core sequencer stand-in: instruction boundaries and division stalls
`timescale 1ns/100ps
module viack_core_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // prompt or slow answering
  input wire logic slow_i,
  // towards the block
  output logic boundary_o,
  output logic div_busy_o
);
  logic [2:0] ph_q;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ph_q <= 3'h0;
    end else begin
      ph_q <= ph_q + 3'h1;
    end
  end
  // slow mode: one boundary in eight cycles, a division stalls the first four
  assign boundary_o = !slow_i || ph_q == 3'h7;
  assign div_busy_o = slow_i && ph_q < 3'h4;
endmodule

// ==== test/viack_sva.sv ====
// checker of stacking order, vectors and status word updates
`timescale 1ns/100ps
module viack_chk
  import viack_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // core instructions
  input wire logic set_enable_instr_i,
  input wire logic clear_enable_instr_i,
  input wire logic break_trap_instr_i,
  input wire logic return_from_irq_instr_i,
  input wire logic return_from_trap_instr_i,
  input wire logic pop_status_instr_i,
  input wire logic [7:0] stack_status_i,
  // acknowledge outputs
  input wire logic [7:0] status_word_o,
  input wire logic push_status_o,
  input wire logic push_pc_o,
  input wire logic vector_load_o,
  input wire logic [15:0] vector_addr_o,
  input wire logic [viack_pkg::SRC_W-1:0] vector_src_o,
  input wire logic trap_active_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic restore;
  assign restore = pop_status_instr_i || return_from_irq_instr_i || return_from_trap_instr_i;
  sequence s_stack;
    push_status_o ##1 push_pc_o ##1 vector_load_o;
  endsequence
  a_stack_order: assert property (push_status_o |-> s_stack)
    else $error("stacking order broken");
  a_irq_vector: assert property (vector_load_o && !trap_active_o |->
    vector_addr_o == VEC_TABLE_BASE + {11'h0, vector_src_o, 1'b0})
    else $error("wrong source vector");
  a_trap_vector: assert property (vector_load_o && trap_active_o |-> vector_addr_o == TRAP_VEC_LO)
    else $error("wrong trap vector");
  a_trap_taken: assert property (break_trap_instr_i |-> ##[1:4] push_status_o && trap_active_o)
    else $error("trap not taken");
  a_reset_value: assert property ($rose(rst_b_i) |-> status_word_o == STATUS_RST)
    else $error("status reset value wrong");
  a_status_restore: assert property (restore |-> ##2 status_word_o == $past(stack_status_i, 2))
    else $error("status not restored");
  a_enable_set: assert property (set_enable_instr_i |-> ##2
    status_word_o == ($past(status_word_o) | 8'h80))
    else $error("enable set wrong");
  a_enable_clear: assert property (clear_enable_instr_i |-> ##2
    status_word_o == ($past(status_word_o) & 8'h7f))
    else $error("enable clear wrong");
  a_gate_enable: assert property ((!status_word_o[IE_BIT]) [*6] |->
    !(push_status_o && !trap_active_o))
    else $error("accepted while disabled");
  a_accept_disable: assert property (vector_load_o |-> ##[1:3] !status_word_o[IE_BIT])
    else $error("enable left set");
endmodule
bind viack_top viack_chk viack_chk_i (.core_clk_i, .rst_b_i, .set_enable_instr_i,
  .clear_enable_instr_i, .break_trap_instr_i, .return_from_irq_instr_i,
  .return_from_trap_instr_i, .pop_status_instr_i, .stack_status_i, .status_word_o,
  .push_status_o, .push_pc_o, .vector_load_o, .vector_addr_o, .vector_src_o, .trap_active_o);

// ==== test/tb_top.sv ====
// self-checking bench of the acknowledge block
`timescale 1ns/100ps
module tb_top;
  import viack_pkg::*;
  logic clk = 0, rst_b = 0, rd = 0, wr = 0, slow = 0, wq, tr, pps, ppc, vld, bnd, dv;
  logic [3:0] ad = 0, vs;
  logic [11:0] pin = 12'h0f0;
  logic [31:0] wd = 0, rdat, q, seed = 32'h2d18;
  logic [8:0] cmd = 0;
  logic [7:0] stk = 0, swd = 0, sw, m = 8'h02;
  logic [2:0] bsel = 0;
  logic [15:0] va, req;
  logic [3:0] ra[5] = '{REG_RISE, REG_FALL, REG_MASK, REG_LEVEL, 4'h2};
  logic [15:0] rv[5] = '{16'h0, 16'h0, 16'hffff, 16'hffff, 16'h0};
  int fail_count = 0, comparisons = 0, cyc = 0, n, k;
  viack_top viack_top_i (.core_clk_i(clk), .rst_b_i(rst_b), .ext_irq_pin_i(pin),
    .periph_req_i(16'h0), .avs_address_i(ad), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_readdata_o(rdat), .avs_waitrequest_o(wq),
    .instr_boundary_i(bnd), .div_busy_i(dv), .set_enable_instr_i(cmd[0]),
    .clear_enable_instr_i(cmd[1]), .break_trap_instr_i(cmd[2]),
    .return_from_irq_instr_i(cmd[3]), .return_from_trap_instr_i(cmd[4]),
    .pop_status_instr_i(cmd[5]), .stack_status_i(stk), .status_wr_i(cmd[6]),
    .status_wdata_i(swd), .status_bit_set_i(cmd[7]), .status_bit_clr_i(cmd[8]),
    .status_bit_sel_i(bsel), .status_word_o(sw), .push_status_o(pps), .push_pc_o(ppc),
    .vector_load_o(vld), .vector_addr_o(va), .vector_src_o(vs), .trap_active_o(tr),
    .ext_irq_request_o(req));
  viack_core_model core_i (.clk_i(clk), .rst_b_i(rst_b), .slow_i(slow), .boundary_o(bnd),
    .div_busy_o(dv));
  initial begin
    forever #2.5 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic tally_and_finish();
    $display("comparisons=%0d mismatches=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    ad <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wq !== 1'b0);
    q = rdat;
    wr <= 0;
    rd <= 0;
  endtask
  // one-cycle instruction pulse, then the status word against the model
  task automatic op(input int c);
    @(posedge clk);
    cmd <= 9'(1 << c);
    @(posedge clk);
    cmd <= 0;
    repeat (3) @(negedge clk);
    chk(sw, m);
  endtask
  task automatic quiet(input int c);
    int j;
    j = 0;
    repeat (c) begin
      @(negedge clk);
      j += int'(pps === 1'b1);
    end
    chk(j, 0);
  endtask
  task automatic take(input logic trap, input logic [3:0] s, input logic lvl);
    k = 0;
    while (pps !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
    chk(ppc, 1);
    @(negedge clk);
    chk(vld & (tr === trap), 1);
    chk(va, trap ? TRAP_VEC_LO : VEC_TABLE_BASE + 16'(2 * s));
    if (!trap) begin
      chk(vs, s);
      m[ISP_BIT] = lvl;
    end
    m[IE_BIT] = 0;
    repeat (3) @(negedge clk);
    chk(sw, m);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1;
    @(negedge clk);
    chk(sw, STATUS_RST);
    bus(1, 4'h2, 32'hffff);
    foreach (ra[i]) begin
      bus(0, ra[i], 32'h0);
      chk(q[15:0], rv[i]);
    end
    m = 8'h82;
    op(0);
    swd <= 8'h41;
    m = 8'h41;
    op(6);
    bsel <= 3'd7;
    m = 8'hc1;
    op(7);
    bsel <= 3'd0;
    m = 8'hc0;
    op(8);
    m = 8'h40;
    op(1);
    stk <= 8'h02;
    m = 8'h02;
    op(5);
    bus(1, REG_RISE, 32'hcc);
    bus(1, REG_FALL, 32'haa);
    repeat (20) begin
      @(posedge clk);
      seed = xs(seed);
      pin <= {seed[3:0], 8'h0f};
    end
    repeat (6) @(negedge clk);
    chk(req, 16'h00ac);
    bus(1, REG_LEVEL, 32'hff7f);
    bus(1, REG_MASK, 32'hff53);
    quiet(40);
    m = 8'h82;
    op(0);
    take(0, 4'd7, 0);
    chk(req[7], 0);
    m = 8'h80;
    op(0);
    quiet(40);
    stk <= 8'h82;
    m = 8'h82;
    op(3);
    take(0, 4'd2, 1);
    for (n = 3; n < 6; n += 2) begin
      m = 8'h82;
      op(0);
      take(0, 4'(n), 1);
    end
    slow <= 1;
    for (n = 1; n >= 0; n--) begin
      bus(1, REG_LEVEL, n ? 32'hffff : 32'hff7b);
      m = 8'h82;
      op(0);
      @(posedge clk);
      pin[2] <= 0;
      repeat (6) @(posedge clk);
      pin[2] <= 1;
      while (req[2] !== 1'b1) @(negedge clk);
      take(0, 4'd2, n[0]);
      chk(k >= MIN_LAT_HI + n && k <= MAX_LAT_HI + n, 1);
    end
    m = 8'h80;
    op(0);
    @(posedge clk);
    cmd <= 9'h4;
    @(posedge clk);
    cmd <= 0;
    take(1, 4'd0, 0);
    stk <= 8'h02;
    m = 8'h02;
    op(4);
    bus(1, REG_RISE, 32'h0);
    bus(1, REG_FALL, 32'h0);
    tally_and_finish();
  end
endmodule
